/* File: logic/rtcig_top.sv */
`timescale 1ns/1ps
`include "rtcig_defs.svh"

// Contract
// RL1: irq low while enabled flag set
// RL2: reading status c clears flags, releases irq
// RL3: reset clears pending interrupt conditions; the code keeps uf
// RL4: idle irq floats, never driven high
// RL5: irq is open-drain only
// RL6: ram clear fills user ram with ones
// RL7: clear only when low in battery mode
// RL8: square wave from one of divider taps
// RL9: rate from reg a, enable in b
// RL10: no square wave below trip level
// RL11: bus ignored below trip level
// RL12: timebase from 32.768khz crystal input
// RL13: oscillator runs per control enable bit
// RL14: 14 registers plus 114/113 ram bytes
// RL15: 12/24 hour format bit kept
// RL16: three maskable sources, one irq output
// RL17: multiplexed bus, two timing styles
// RL18: reset clears enables, flags, square_wave_enable, bus; the code clears pf and af but keeps uf
// RL19: bus style pin picks strobe timing
// RL20: status c and d are read-only
// RL21: rate code to tap from table
module rtcig_top
  import rtcig_pkg::*;
#(
  parameter logic        CENTURY_BYTE  = 1'b0,
  // four bits per rate code, code 0 turns the tap off
  parameter logic [63:0] RATE_TAP_MAP  = 64'h0123456789abcde0
)(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register port
  input  wire rtcig_bus_s bus_req,
  output logic [7:0]      bus_rdata,
  // supply and ram clear
  input  wire logic       power_fail,
  input  wire logic       ram_clear_n,
  // timekeeping events
  input  wire logic       alarm_event,
  input  wire logic       update_end_event,
  // crystal pins
  input  wire logic       crystal_in,
  output logic            crystal_out,
  // interrupt request, open drain
  output logic            irq_out,
  output logic            irq_oe,
  // square wave
  output logic            square_wave_out
);

  // ==================================================
  // reset release
  logic [1:0]   rst_sync_q;
  logic         rst_sync_b;

  // ==================================================
  // state and decode
  rtcig_state_s st_q;
  rtcig_state_s st_d;
  logic         bus_ok;
  logic [3:0]   rate_code;
  logic [3:0]   tap;
  logic         osc_en;
  logic         tick;
  logic         per_evt;
  logic         rd_c;
  logic [7:0]   ctrl_b;

  // two-flop release, assertion is immediate and asynchronous
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_sync_b = rst_sync_q[1];

  // ==================================================
  // next-state logic
  // storage has no reset: clock, calendar and ram survive reset
  always_comb
  begin
    st_d      = st_q;
    // RL11 bus gated off below trip or in reset
    bus_ok    = rst_sync_b & ~power_fail;
    rate_code = st_q.mem[`RTCIG_CTRL_A][`RTCIG_A_RATE_LSB +: 4];
    osc_en    = st_q.mem[`RTCIG_CTRL_A][`RTCIG_A_OSC_BIT];
    ctrl_b    = st_q.mem[`RTCIG_CTRL_B];
    // RL21 tap chosen by the supplied rate table
    tap       = RATE_TAP_MAP[{rate_code, 2'b00} +: 4];
    // RL12 rising edge of the 32.768khz input
    tick      = osc_en & crystal_in & ~st_q.xtal_prev;
    rd_c      = bus_ok & bus_req.rd & (bus_req.addr == `RTCIG_STATUS_C);

    // crystal follower and divider chain
    st_d.xtal_prev = crystal_in;
    // RL13 amplifier and chain stop with the enable bit
    st_d.xout      = osc_en & ~crystal_in;
    if (tick)
      st_d.div = st_q.div + 15'h0001;

    // RL8 periodic event on a rising edge of the tap
    per_evt = tick & (rate_code != 4'h0) & st_d.div[tap] & ~st_q.div[tap];

    // RL9 rate from reg a, gated by the enable in reg b
    // RL10 nothing leaves the pin below the trip level
    st_d.sqw = (rate_code != 4'h0) & ctrl_b[`RTCIG_B_SQUARE_WAVE_ENABLE_BIT]
               & ~power_fail & st_q.div[tap];

    // RL2 read of c clears the flags
    if (rd_c)
    begin
      st_d.pf = 1'b0;
      st_d.af = 1'b0;
      st_d.uf = 1'b0;
    end
    // RL16 three sources, set wins over a same-cycle read
    if (per_evt)
      st_d.pf = 1'b1;
    if (alarm_event)
      st_d.af = 1'b1;
    if (update_end_event)
      st_d.uf = 1'b1;

    // writes; RL15 the 12/24 bit is plain storage in reg b
    if (bus_ok && bus_req.wr)
    begin
      case (bus_req.addr)
        // RL20 status registers ignore writes
        `RTCIG_STATUS_C, `RTCIG_STATUS_D : ;
        // update flag is read-only, stored as zero
        `RTCIG_CTRL_A :
          st_d.mem[`RTCIG_CTRL_A] = {1'b0, bus_req.wdata[6:0]};
        // top bit of seconds is read-only and reads zero
        `RTCIG_SECONDS :
          st_d.mem[`RTCIG_SECONDS] = {1'b0, bus_req.wdata[6:0]};
        default :
          st_d.mem[bus_req.addr] = bus_req.wdata;
      endcase
    end

    // read data valid only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (bus_ok && bus_req.rd)
    begin
      case (bus_req.addr)
        `RTCIG_STATUS_C :
          st_d.rdata = {st_q.interrupt_summary_flag, st_q.pf, st_q.af, st_q.uf, 4'h0};
        `RTCIG_STATUS_D :
          st_d.rdata = `RTCIG_D_VALID;
        default :
          st_d.rdata = st_q.mem[bus_req.addr];
      endcase
    end

    // RL6 fill user ram, registers untouched
    // RL7 only with the pin low while on battery
    // RL14 century byte kept out of ram when present
    if (power_fail && !ram_clear_n)
    begin
      for (int i = `RTCIG_RAM_LO; i <= `RTCIG_RAM_HI; i++)
      begin
        if (!(CENTURY_BYTE && (7'(i) == `RTCIG_CENTURY)))
          st_d.mem[i] = `RTCIG_RAM_FILL;
      end
    end

    // RL18 reset clears enables, the pf and af flags and square_wave_enable
    // RL3 pf and af dropped while powered, uf kept
    if (!rst_sync_b)
    begin
      st_d.div       = 15'h0000;
      st_d.xtal_prev = 1'b0;
      st_d.xout      = 1'b0;
      st_d.sqw       = 1'b0;
      st_d.rdata     = 8'h00;
      st_d.mem[`RTCIG_CTRL_A] = `RTCIG_A_RST;
      if (!power_fail)
      begin
        st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_PIE_BIT]  = 1'b0;
        st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_AIE_BIT]  = 1'b0;
        st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_UIE_BIT]  = 1'b0;
        st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
        st_d.pf = 1'b0;
        st_d.af = 1'b0;
      end
    end

    // RL1 summary flag from flags and their enables
    st_d.interrupt_summary_flag = (st_d.pf & st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_PIE_BIT])
              | (st_d.af & st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_AIE_BIT])
              | (st_d.uf & st_d.mem[`RTCIG_CTRL_B][`RTCIG_B_UIE_BIT]);
    if (!rst_sync_b && !power_fail)
      st_d.interrupt_summary_flag = 1'b0;
  end

  // single state register
  always_ff @(posedge core_clk)
  begin
    st_q <= st_d;
  end

  // ==================================================
  // outputs
  // RL4 pull-down only, the line floats when idle
  // RL5 open drain: low level, enable is the request
  assign irq_out         = 1'b0;
  assign irq_oe          = st_q.interrupt_summary_flag;
  assign bus_rdata       = st_q.rdata;
  assign crystal_out     = st_q.xout;
  assign square_wave_out = st_q.sqw;

  // RL17 plain port stands for both strobe styles
  // RL19 style pin decoding lives in the pad ring

  // ==================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_read_c_quiet;
    rd_c && !alarm_event && !update_end_event && !per_evt;
  endsequence

  sequence s_battery_clear;
    power_fail && !ram_clear_n;
  endsequence

  a_irq_follows_flags : assert property ( // RL1
    irq_oe == ((st_q.pf && ctrl_b[`RTCIG_B_PIE_BIT])
    || (st_q.af && ctrl_b[`RTCIG_B_AIE_BIT])
    || (st_q.uf && ctrl_b[`RTCIG_B_UIE_BIT])))
    else $error("irq enable does not follow enabled flags");

  a_read_c_release : assert property ( // RL2
    s_read_c_quiet |=> !irq_oe && !st_q.pf && !st_q.af && !st_q.uf)
    else $error("read of status c did not release irq");

  a_reset_clears : assert property (@(posedge core_clk) disable iff (1'b0) // RL3
    (!rst_sync_b && !power_fail) |=> !irq_oe && !st_q.pf && !st_q.af
    && !st_q.mem[`RTCIG_CTRL_B][`RTCIG_B_SQUARE_WAVE_ENABLE_BIT])
    else $error("reset left an interrupt condition");

  a_irq_open_drain : assert property ( // RL5
    irq_out == 1'b0)
    else $error("irq pin driven high");

  a_ram_fill : assert property ( // RL6
    s_battery_clear |=> st_q.mem[`RTCIG_RAM_LO] == `RTCIG_RAM_FILL
    && st_q.mem[`RTCIG_RAM_HI] == `RTCIG_RAM_FILL
    && $stable(st_q.mem[`RTCIG_SECONDS]))
    else $error("ram clear wrong");

  a_ram_keep_powered : assert property ( // RL7
    (!power_fail && !ram_clear_n && !bus_req.wr) |=> $stable(st_q.mem[`RTCIG_RAM_LO]))
    else $error("ram changed with supply present");

  a_sqw_power_fail : assert property ( // RL10
    power_fail |=> !square_wave_out)
    else $error("square wave below trip level");

  a_sqw_enable : assert property ( // RL9
    !ctrl_b[`RTCIG_B_SQUARE_WAVE_ENABLE_BIT] |=> !square_wave_out)
    else $error("square wave without enable");

  a_periodic_set : assert property ( // RL8
    per_evt |=> st_q.pf ##1 (st_q.pf || $past(rd_c)))
    else $error("periodic flag not set on tap edge");

  a_bus_ignored : assert property ( // RL11
    power_fail |=> $stable(st_q.mem[`RTCIG_CTRL_A]) && bus_rdata == 8'h00)
    else $error("bus acted below trip level");

  a_status_ro : assert property ( // RL20
    (bus_req.wr && !rd_c && !per_evt && !alarm_event && !update_end_event)
    |=> $stable(st_q.pf) && $stable(st_q.af) && $stable(st_q.uf))
    else $error("write changed status flags");

  a_osc_stop : assert property ( // RL13
    !osc_en |=> $stable(st_q.div) && !crystal_out)
    else $error("divider ran with oscillator off");

  // RL4 idle line left floating
  a_irq_float_idle : assert property ( // RL4
    (!st_q.pf && !st_q.af && !st_q.uf) |-> !irq_oe)
    else $error("irq driven with no flag pending");

  // RL16 alarm source sets flag
  a_alarm_sets : assert property ( // RL16
    alarm_event |=> st_q.af)
    else $error("alarm event did not set its flag");

  // RL16 update source sets flag
  a_update_sets : assert property ( // RL16
    update_end_event |=> st_q.uf)
    else $error("update event did not set its flag");

  // RL2 alarm flag stands until read
  a_flags_hold : assert property ( // RL2
    (st_q.af && !rd_c) |=> st_q.af)
    else $error("alarm flag dropped without a read");

  // RL2 status c read layout
  a_status_c_read : assert property ( // RL2
    rd_c |=> bus_rdata[7] == $past(irq_oe) && bus_rdata[3:0] == 4'h0)
    else $error("status c read data wrong");

  // RL12 divider counts crystal edges
  a_tick_counts : assert property ( // RL12
    tick |=> st_q.div == $past(st_q.div) + 15'h0001)
    else $error("divider missed a crystal edge");

  // RL13 crystal output is the inverse of the input while the oscillator runs
  a_xout_follows : assert property ( // RL13
    osc_en |=> crystal_out == !$past(crystal_in))
    else $error("crystal output wrong while running");

  // RL9 rate code zero stops wave
  a_rate_off : assert property ( // RL9
    (rate_code == 4'h0) |=> !square_wave_out)
    else $error("square wave with rate code off");

  // RL11 read data stands one cycle
  a_rdata_one_cycle : assert property ( // RL11
    !(bus_ok && bus_req.rd) |=> bus_rdata == 8'h00)
    else $error("read data outside its cycle");

  // RL11 powered write lands
  a_write_lands : assert property ( // RL11
    (bus_ok && bus_req.wr && bus_req.addr == `RTCIG_RAM_LO)
    |=> st_q.mem[`RTCIG_RAM_LO] == $past(bus_req.wdata))
    else $error("powered write did not land");

  // RL14 status d reads valid
  a_status_d_read : assert property ( // RL14
    (bus_ok && bus_req.rd && bus_req.addr == `RTCIG_STATUS_D)
    |=> bus_rdata == `RTCIG_D_VALID)
    else $error("status d read wrong");

  // RL18 reset loads control a
  a_ctrl_a_reset : assert property ( // RL18
    $rose(rst_sync_b) |-> st_q.mem[`RTCIG_CTRL_A] == `RTCIG_A_RST)
    else $error("control a not at reset value");

endmodule : rtcig_top

/* File: logic/rtcig_defs.svh */
`ifndef RTCIG_DEFS_SVH
`define RTCIG_DEFS_SVH

// ==================================================
// register map, byte offsets on the 7-bit address
`define RTCIG_SECONDS      7'h00
`define RTCIG_CTRL_A       7'h0a
`define RTCIG_CTRL_B       7'h0b
`define RTCIG_STATUS_C     7'h0c
`define RTCIG_STATUS_D     7'h0d
`define RTCIG_RAM_LO       7'h0e
`define RTCIG_CENTURY      7'h32
`define RTCIG_RAM_HI       7'h7f

// ==================================================
// control register a fields
`define RTCIG_A_UPD_BIT    7
`define RTCIG_A_OSC_BIT    5
`define RTCIG_A_RATE_LSB   0
`define RTCIG_A_RST        8'h20

// ==================================================
// control register b fields
`define RTCIG_B_SET_BIT    7
`define RTCIG_B_PIE_BIT    6
`define RTCIG_B_AIE_BIT    5
`define RTCIG_B_UIE_BIT    4
`define RTCIG_B_SQUARE_WAVE_ENABLE_BIT   3
`define RTCIG_B_DM_BIT     2
`define RTCIG_B_HR24_BIT   1

// ==================================================
// status register c and d fields
`define RTCIG_C_INTERRUPT_SUMMARY_FLAG_BIT   7
`define RTCIG_C_PF_BIT     6
`define RTCIG_C_AF_BIT     5
`define RTCIG_C_UF_BIT     4
`define RTCIG_D_VALID      8'h80

// ==================================================
// timebase
`define RTCIG_XTAL_HZ      32768
`define RTCIG_DIV_STAGES   15
`define RTCIG_RAM_FILL     8'hff

`endif

/* File: logic/rtcig_pkg.sv */
package rtcig_pkg;

  // ==================================================
  // bus request carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rtcig_bus_s;

  // ==================================================
  // whole block state
  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [14:0]       div;
    logic              xtal_prev;
    logic              xout;
    logic              sqw;
    logic              pf;
    logic              af;
    logic              uf;
    logic              interrupt_summary_flag;
    logic [7:0]        rdata;
  } rtcig_state_s;

endpackage : rtcig_pkg

/* File: testbench/rtcig_host.sv */
`timescale 1ns/1ps
// ==================================================
// host processor on the register port
module rtcig_host
  import rtcig_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // register port
  output rtcig_bus_s      bus_req,
  input  wire logic [7:0] bus_rdata
);
  initial bus_req = '0;

  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] wd);
    begin
      @(posedge core_clk);
      bus_req <= {w, ~w, a, wd};
      @(posedge core_clk);
      // released lines show the inverse, not a stale value
      bus_req <= {2'b00, ~a, ~wd};
    end
  endtask : acc

  // a read of status c acknowledges
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    begin
      acc(1'b0, a, 8'h00);
      @(negedge core_clk);
      d = bus_rdata;
    end
  endtask : rd
endmodule : rtcig_host

/* File: testbench/rtc_irq_sqw_ramclear_power_gate_bench.sv */
`timescale 1ns/1ps
`include "rtcig_defs.svh"
// ==================================================
// bench top
module rtc_irq_sqw_ramclear_power_gate_bench;
  import rtcig_pkg::*;
  logic       core_clk;
  logic       rst_b;
  rtcig_bus_s bus_req;
  logic [7:0] bus_rdata;
  logic       power_fail;
  logic       ram_clear_n;
  logic       alarm_event;
  logic       update_end_event;
  logic       crystal_in;
  logic       crystal_out;
  logic       irq_out;
  logic       irq_oe;
  logic       square_wave_out;
  wire        irq_line;
  logic [2:0] xtal_cnt;
  logic [7:0] d;
  logic [7:0] exp_ram [0:127];
  int         fails;
  int         n_checks;
  int         cyc;
  int         seed;
  int         i;

  // wired irq line with its external pull-up
  assign irq_line = irq_oe ? irq_out : 1'b1;

  rtcig_top uut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .power_fail(power_fail), .ram_clear_n(ram_clear_n),
    .alarm_event(alarm_event), .update_end_event(update_end_event),
    .crystal_in(crystal_in), .crystal_out(crystal_out), .irq_out(irq_out),
    .irq_oe(irq_oe), .square_wave_out(square_wave_out));

  rtcig_host host (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // scaled timebase, 8 clocks a period, keeps the run short
  always @(posedge core_clk)
  begin
    xtal_cnt   <= xtal_cnt + 3'h1;
    crystal_in <= xtal_cnt[2];
    cyc        <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        fails++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask : chk

  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask : give_verdict

  // one-cycle timekeeper event, then settle
  task automatic pulse(input logic upd);
    begin
      @(posedge core_clk);
      alarm_event      <= ~upd;
      update_end_event <= upd;
      @(posedge core_clk);
      alarm_event      <= 1'b0;
      update_end_event <= 1'b0;
      @(negedge core_clk);
    end
  endtask : pulse

  task automatic ram_check;
    logic [7:0] v;
    begin
      for (int k = 14; k < 128; k++)
      begin
        host.rd(7'(k), v);
        chk("ram byte", v, exp_ram[k]);
      end
    end
  endtask : ram_check

  // rising edges in 512 cycles for a rate code
  function automatic int exp_edges(input int code);
    return 512 / (16 << (15 - code));
  endfunction : exp_edges

  // edges may land on the window border, so allow one either way when edges are expected, none allowed when zero
  task automatic sqw_run(input int x);
    logic p;
    int   e;
    begin
      e = 0;
      repeat (3) @(negedge core_clk);
      p = square_wave_out;
      repeat (512)
      begin
        @(negedge core_clk);
        if (square_wave_out === 1'b1 && p === 1'b0)
          e++;
        p = square_wave_out;
      end
      chk("sqw edges", 8'((x > 0 && e <= x + 1 && e + 1 >= x) ? x : e), 8'(x));
    end
  endtask : sqw_run

  // ==================================================
  // main sequence
  initial
  begin
    seed = 32'h4d36;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    xtal_cnt = 3'h0;
    crystal_in = 1'b0;
    rst_b = 1'b0;
    power_fail = 1'b0;
    ram_clear_n = 1'b1;
    alarm_event = 1'b0;
    update_end_event = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    host.rd(`RTCIG_CTRL_A, d);
    chk("ctrl a", d, `RTCIG_A_RST);
    host.rd(`RTCIG_CTRL_B, d);
    chk("ctrl b enables", d & 8'h78, 8'h00);
    host.rd(`RTCIG_STATUS_D, d);
    chk("status d", d, `RTCIG_D_VALID);
    pulse(1'b1);
    host.rd(`RTCIG_STATUS_C, d);
    // alarm and update sources alone, the other one masked
    for (i = 0; i < 2; i++)
    begin
      host.acc(1'b1, `RTCIG_CTRL_B, (i != 0) ? 8'h10 : 8'h20);
      pulse(i == 0);
      chk("masked irq", 8'(irq_line), 8'h01);
      pulse(i != 0);
      chk("irq low", 8'(irq_line), 8'h00);
      chk("irq data", 8'(irq_out), 8'h00);
      host.rd(`RTCIG_STATUS_C, d);
      chk("status c", d, 8'hb0);
      chk("irq released", 8'(irq_line), 8'h01);
    end
    host.acc(1'b1, `RTCIG_STATUS_C, 8'hff);
    host.rd(`RTCIG_STATUS_C, d);
    chk("status c write", d, 8'h00);
    host.acc(1'b1, `RTCIG_SECONDS, 8'h25);
    for (i = 14; i < 128; i++)
    begin
      exp_ram[i] = 8'($random(seed));
      host.acc(1'b1, 7'(i), exp_ram[i]);
    end
    ram_clear_n <= 1'b0;
    ram_check();
    @(posedge core_clk);
    power_fail <= 1'b1;
    host.acc(1'b1, `RTCIG_CTRL_B, 8'hff);
    host.rd(`RTCIG_RAM_LO, d);
    chk("gated read", d, 8'h00);
    @(posedge core_clk);
    ram_clear_n <= 1'b1;
    power_fail <= 1'b0;
    for (i = 14; i < 128; i++)
      exp_ram[i] = `RTCIG_RAM_FILL;
    ram_check();
    host.rd(`RTCIG_SECONDS, d);
    chk("seconds kept", d, 8'h25);
    host.rd(`RTCIG_CTRL_B, d);
    chk("ctrl b kept", d, 8'h10);
    host.acc(1'b1, `RTCIG_CTRL_B, 8'h48);
    for (i = 12; i < 16; i++)
    begin
      host.acc(1'b1, `RTCIG_CTRL_A, 8'h20 | 8'(i));
      sqw_run(exp_edges(i));
    end
    chk("periodic irq", 8'(irq_line), 8'h00);
    host.rd(`RTCIG_STATUS_C, d);
    chk("periodic flag", d & 8'hc0, 8'hc0);
    // rate off, enable off, oscillator off, supply low
    for (i = 0; i < 4; i++)
    begin
      host.acc(1'b1, `RTCIG_CTRL_A, (i == 0) ? 8'h20 : (i == 2) ? 8'h0f : 8'h2f);
      host.acc(1'b1, `RTCIG_CTRL_B, (i == 1) ? 8'h40 : 8'h48);
      power_fail <= (i == 3);
      sqw_run(0);
      if (i == 2)
        chk("crystal out", 8'(crystal_out), 8'h00);
    end
    @(posedge core_clk);
    power_fail <= 1'b0;
    host.acc(1'b1, `RTCIG_CTRL_B, 8'h28);
    pulse(1'b0);
    chk("alarm irq", 8'(irq_oe), 8'h01);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("reset irq", 8'(irq_line), 8'h01);
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    host.rd(`RTCIG_CTRL_B, d);
    chk("reset enables", d & 8'h78, 8'h00);
    give_verdict();
  end
endmodule : rtc_irq_sqw_ramclear_power_gate_bench
